// ===== verilog/fpu_exc_pkg.sv
package fpu_exc_pkg;

    // Register offsets on the APB.
    localparam logic [11:0] FP_STATUS_CONTROL_REG_OFS = 12'h000;
    localparam logic [11:0] SRC_OFS = 12'h004;
    localparam logic [11:0] EVT_OFS = 12'h008;
    localparam logic [11:0] CORE_OFS = 12'h00C;

    // Field positions of fp_status_control_reg.
    localparam int RM_LSB = 0;
    localparam int FLAG_LSB = 2;
    localparam int EN_LSB = 7;
    localparam int CAUSE_LSB = 12;
    localparam int DN_BIT = 18;
    localparam int SZ_BIT = 20;
    localparam int FR_BIT = 21;
    localparam logic [31:0] FP_STATUS_CONTROL_REG_WMASK = 32'h0037FFFF;
    localparam logic [31:0] FP_STATUS_CONTROL_REG_RESET = 32'h00040001;

    // Cause source indices: inexact, underflow, overflow, zero-div, invalid, error.
    localparam int SRC_I = 0;
    localparam int SRC_U = 1;
    localparam int SRC_O = 2;
    localparam int SRC_Z = 3;
    localparam int SRC_V = 4;
    localparam int SRC_E = 5;

    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;

    localparam int CTRL_LOAD_CYCLES = 4;

    typedef enum {
        OP_OTHER,
        OP_DIV,
        OP_INNER,
        OP_MATRIX,
        OP_BANK,
        OP_SIZE,
        OP_MOVE
    } op_e;

    // One completing FP instruction from the pipeline.
    typedef struct packed {
        logic [2:0] op;
        logic in_slot;
        logic denorm_in;
        logic invalid;
        logic zero_div;
        logic ovf;
        logic unf;
        logic inexact;
        logic may_ovf;
        logic may_unf;
        logic may_inx;
        logic sign;
    } fp_op_s;

    // Result kind for untrapped outcomes.
    localparam logic [2:0] RES_NORMAL = 3'h0;
    localparam logic [2:0] RES_QNAN = 3'h1;
    localparam logic [2:0] RES_INF = 3'h2;
    localparam logic [2:0] RES_MAXNORM = 3'h3;
    localparam logic [2:0] RES_DENORM = 3'h4;
    localparam logic [2:0] RES_ZERO = 3'h5;
    localparam logic [2:0] RES_INEXACT = 3'h6;

    typedef struct packed {
        logic trap;
        logic illegal;
        logic slot_illegal;
        logic wb_en;
        logic [2:0] res_kind;
        logic res_sign;
        logic pair_xfer;
    } fp_resp_s;

endpackage

// ===== verilog/fpu_exc_ctl.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fpu_exc_ctl
    import fpu_exc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pipeline side.
    input wire logic op_valid_i,
    input wire fp_op_s op_i,
    output logic op_ready_o,
    output fp_resp_s resp_o,
    output logic resp_valid_o,
    output logic fp_trap_o
);

    logic [31:0] fp_status_control_reg;
    logic fp_disable_bit;
    logic [7:0] trap_count;
    logic [2:0] load_wait;
    logic load_busy;
    logic [31:0] load_data;

    logic [1:0] rounding_select_field;
    logic [4:0] flag_f;
    logic [4:0] en_f;
    logic denorm_flush_bit;
    logic pair_transfer_size_bit;
    logic fp_bank_select_bit;

    assign rounding_select_field = fp_status_control_reg[RM_LSB +: 2];
    assign flag_f = fp_status_control_reg[FLAG_LSB +: 5];
    assign en_f = fp_status_control_reg[EN_LSB +: 5];
    assign denorm_flush_bit = fp_status_control_reg[DN_BIT];
    assign pair_transfer_size_bit = fp_status_control_reg[SZ_BIT];
    assign fp_bank_select_bit = fp_status_control_reg[FR_BIT];

    logic take;
    logic [5:0] cause;
    logic trap_now;
    logic is_matrix;
    logic is_inner;
    logic is_div;
    logic apb_acc;
    logic apb_wr;

    assign apb_acc = psel_i && penable_i && pready_o;
    assign apb_wr = apb_acc && pwrite_i;
    assign take = op_valid_i && op_ready_o && !fp_disable_bit;
    assign is_matrix = (op_i.op == 3'(OP_MATRIX));
    assign is_inner = (op_i.op == 3'(OP_INNER));
    assign is_div = (op_i.op == 3'(OP_DIV));

    // Sources; geometric instructions are approximate so always inexact.
    always_comb begin
        cause = 6'h00;
        cause[SRC_E] = op_i.denorm_in && !denorm_flush_bit;
        cause[SRC_V] = op_i.invalid;
        cause[SRC_Z] = is_div && op_i.zero_div;
        cause[SRC_O] = op_i.ovf;
        cause[SRC_U] = op_i.unf;
        cause[SRC_I] = op_i.inexact || op_i.ovf || op_i.unf || is_inner || is_matrix;
    end

    // Enables other than zero-div trap on possibility, so a trap may leave cause all zero.
    always_comb begin
        trap_now = cause[SRC_E];
        if (en_f[SRC_V] && (is_matrix || op_i.invalid)) begin
            trap_now = 1'b1;
        end
        if (en_f[SRC_Z] && cause[SRC_Z]) begin
            trap_now = 1'b1;
        end
        if (en_f[SRC_O] && (op_i.may_ovf || op_i.ovf)) begin
            trap_now = 1'b1;
        end
        if (en_f[SRC_U] && (op_i.may_unf || op_i.unf)) begin
            trap_now = 1'b1;
        end
        if (en_f[SRC_I] && (op_i.may_inx || cause[SRC_I])) begin
            trap_now = 1'b1;
        end
    end

    // Control loads stall the pipeline for several cycles to keep FP state consistent.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_wait <= 3'h0;
            load_busy <= 1'b0;
            load_data <= 32'h00000000;
        end else if (apb_wr && paddr_i == FP_STATUS_CONTROL_REG_OFS) begin
            load_busy <= 1'b1;
            load_wait <= 3'(CTRL_LOAD_CYCLES - 1);
            load_data <= pwdata_i & FP_STATUS_CONTROL_REG_WMASK;
        end else if (load_busy) begin
            if (load_wait == 3'h0) begin
                load_busy <= 1'b0;
            end else begin
                load_wait <= load_wait - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_ready_o <= 1'b1;
        end else begin
            op_ready_o <= !(load_busy && load_wait != 3'h0) && !(apb_wr && paddr_i == FP_STATUS_CONTROL_REG_OFS);
        end
    end

    // Status/control register: cause, flags and mode bits updated in the completing cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fp_status_control_reg <= FP_STATUS_CONTROL_REG_RESET;
        end else if (load_busy && load_wait == 3'h0) begin
            fp_status_control_reg <= load_data;
        end else if (take) begin
            fp_status_control_reg[CAUSE_LSB +: 6] <= cause;
            // Flags record every source except the error source, even when the operation traps, so a handler sees the history.
            fp_status_control_reg[FLAG_LSB +: 5] <= flag_f | cause[4:0];
            if (op_i.op == 3'(OP_BANK)) begin
                fp_status_control_reg[FR_BIT] <= !fp_bank_select_bit;
            end
            if (op_i.op == 3'(OP_SIZE)) begin
                fp_status_control_reg[SZ_BIT] <= !pair_transfer_size_bit;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fp_disable_bit <= 1'b0;
        end else if (apb_wr && paddr_i == CORE_OFS) begin
            fp_disable_bit <= pwdata_i[0];
        end
    end

    // Response: trap, illegal, writeback and default result kind.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_o <= '0;
            resp_valid_o <= 1'b0;
            fp_trap_o <= 1'b0;
        end else begin
            resp_valid_o <= op_valid_i && op_ready_o;
            fp_trap_o <= take && trap_now;
            resp_o <= '0;
            if (op_valid_i && op_ready_o && fp_disable_bit) begin
                resp_o.illegal <= !op_i.in_slot;
                resp_o.slot_illegal <= op_i.in_slot;
            end else if (take) begin
                resp_o.trap <= trap_now;
                resp_o.wb_en <= !trap_now;
                resp_o.res_sign <= op_i.sign;
                resp_o.pair_xfer <= (op_i.op == 3'(OP_MOVE)) && pair_transfer_size_bit;
                if (cause[SRC_V]) begin
                    resp_o.res_kind <= RES_QNAN;
                end else if (cause[SRC_Z]) begin
                    resp_o.res_kind <= RES_INF;
                end else if (cause[SRC_O]) begin
                    resp_o.res_kind <= (rounding_select_field == RM_ZERO) ?
                        RES_MAXNORM : RES_INF;
                end else if (cause[SRC_U]) begin
                    resp_o.res_kind <= denorm_flush_bit ? RES_ZERO : RES_DENORM;
                end else if (cause[SRC_I]) begin
                    resp_o.res_kind <= RES_INEXACT;
                end else begin
                    resp_o.res_kind <= RES_NORMAL;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trap_count <= 8'h00;
        end else if (take && trap_now) begin
            trap_count <= trap_count + 8'h01;
        end
    end

    // APB: zero-wait, unmapped addresses answer with an error.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    FP_STATUS_CONTROL_REG_OFS: prdata_o <= fp_status_control_reg;
                    SRC_OFS: prdata_o <= {26'h0, fp_status_control_reg[CAUSE_LSB +: 6]};
                    EVT_OFS: prdata_o <= {24'h0, trap_count};
                    CORE_OFS: prdata_o <= {31'h0, fp_disable_bit};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/fpu_exc_ctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fpu_exc_ctl_asserts
    import fpu_exc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register bus.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Pipeline side.
    input wire logic op_valid_i,
    input wire fp_op_s op_i,
    input wire logic op_ready_o,
    input wire fp_resp_s resp_o,
    input wire logic resp_valid_o,
    input wire logic fp_trap_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_take; op_valid_i && op_ready_o; endsequence
    sequence s_wr; psel_i && penable_i && pready_o && pwrite_i && paddr_i == FP_STATUS_CONTROL_REG_OFS; endsequence
    // A control load may stall the pipe but must never lock it up.
    sequence s_stall; !op_ready_o [*3] ##[1:4] op_ready_o; endsequence
    property p_answer; s_take |=> resp_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("no response after take");
    property p_load; s_wr |=> s_stall; endproperty
    a_load: assert property (p_load) else $error("control load timing wrong");
    property p_ready; psel_i && !penable_i |=> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("bus access not answered");
    property p_err; pready_o && paddr_i[1:0] == 2'h0 |-> pslverr_o == (paddr_i > CORE_OFS); endproperty
    a_err: assert property (p_err) else $error("bus error wrong");
    property p_trap; resp_valid_o && resp_o.trap |-> fp_trap_o; endproperty
    a_trap: assert property (p_trap) else $error("trap without event");
    property p_nowb; fp_trap_o |-> resp_valid_o && !resp_o.wb_en; endproperty
    a_nowb: assert property (p_nowb) else $error("trap wrote result");
    property p_slot; resp_valid_o && resp_o.slot_illegal |-> $past(op_i.in_slot); endproperty
    a_slot: assert property (p_slot) else $error("slot illegal outside slot");
    property p_pair; resp_o.pair_xfer && resp_valid_o |-> $past(op_i.op) == 3'(OP_MOVE); endproperty
    a_pair: assert property (p_pair) else $error("pair transfer on non-move");
endmodule
bind fpu_exc_ctl fpu_exc_ctl_asserts chk_u (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pready_o, .pslverr_o, .op_valid_i, .op_i, .op_ready_o, .resp_o, .resp_valid_o,
    .fp_trap_o);
`default_nettype wire

// ===== tb/pipe_issuer.sv
`timescale 1ns/1ps
`default_nettype none
module pipe_issuer
    import fpu_exc_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Issue handshake.
    input wire logic op_ready_i,
    output logic op_valid_o,
    output fp_op_s op_o
);
    initial begin
        op_valid_o = 1'b0;
        op_o = '0;
    end
    // After the take the bus shows inverted junk, so a stale op is never reused.
    task automatic issue(input fp_op_s op);
        op_valid_o <= 1'b1;
        op_o <= op;
        do @(posedge clk_i); while (op_ready_i !== 1'b1);
        op_valid_o <= 1'b0;
        op_o <= ~op;
    endtask
endmodule
`default_nettype wire

// ===== tb/test_fpu_exception_and_graphics_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module test_fpu_exception_and_graphics_ctl
    import fpu_exc_pkg::*;
();
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o, rd_v;
    logic pready_o, pslverr_o, op_valid_i, op_ready_o, resp_valid_o, fp_trap_o, err;
    fp_op_s op_i;
    fp_resp_s resp_o, r;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    fpu_exc_ctl dut_u (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .op_valid_i, .op_i, .op_ready_o, .resp_o,
        .resp_valid_o, .fp_trap_o);
    pipe_issuer pipe_u (.clk_i, .op_ready_i(op_ready_o), .op_valid_o(op_valid_i), .op_o(op_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd_v = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rd_v, e);
    endtask
    // Low bits hold in_slot, denorm, invalid, zero_div, ovf, unf, inexact, may_*, sign.
    function automatic fp_op_s mk(input op_e k, input logic [10:0] b);
        return {3'(k), b};
    endfunction
    task automatic run(input fp_op_s o, input logic t);
        pipe_u.issue(o);
        @(posedge clk_i);
        r = resp_o;
        chk(resp_valid_o, 1'b1);
        chk(fp_trap_o, t);
        chk(r.trap, t);
        chk(r.trap & r.wb_en, 1'b0);
    endtask
    task automatic t_reset();
        rd(FP_STATUS_CONTROL_REG_OFS, FP_STATUS_CONTROL_REG_RESET);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(err, 1'b1);
    endtask
    task automatic t_disable();
        apb(1'b1, CORE_OFS, 32'h00000001);
        run(mk(OP_OTHER, 11'h000), 1'b0);
        chk(r.illegal, 1'b1);
        run(mk(OP_OTHER, 11'h400), 1'b0);
        chk(r.slot_illegal, 1'b1);
        apb(1'b1, CORE_OFS, 32'h00000000);
    endtask
    task automatic t_untrapped();
        apb(1'b1, FP_STATUS_CONTROL_REG_OFS, 32'h00000000);
        run(mk(OP_DIV, 11'h081), 1'b0);
        chk({r.res_kind, r.res_sign}, {RES_INF, 1'b1});
        rd(FP_STATUS_CONTROL_REG_OFS, 32'h00008020);
        run(mk(OP_OTHER, 11'h100), 1'b0);
        chk(r.res_kind, RES_QNAN);
        rd(FP_STATUS_CONTROL_REG_OFS, 32'h00010060);
        run(mk(OP_OTHER, 11'h041), 1'b0);
        chk({r.res_kind, r.res_sign}, {RES_INF, 1'b1});
        run(mk(OP_MATRIX, 11'h000), 1'b0);
        rd(FP_STATUS_CONTROL_REG_OFS, 32'h00001074);
        apb(1'b1, FP_STATUS_CONTROL_REG_OFS, 32'h00000001);
        run(mk(OP_OTHER, 11'h040), 1'b0);
        chk({r.res_kind, r.res_sign}, {RES_MAXNORM, 1'b0});
        apb(1'b1, FP_STATUS_CONTROL_REG_OFS, 32'h00040000);
        run(mk(OP_OTHER, 11'h021), 1'b0);
        chk({r.res_kind, r.res_sign}, {RES_ZERO, 1'b1});
        apb(1'b1, FP_STATUS_CONTROL_REG_OFS, 32'h00000000);
        run(mk(OP_OTHER, 11'h020), 1'b0);
        chk({r.res_kind, r.res_sign}, {RES_DENORM, 1'b0});
        run(mk(OP_OTHER, 11'h010), 1'b0);
        chk(r.res_kind, RES_INEXACT);
    endtask
    task automatic t_denorm();
        apb(1'b1, FP_STATUS_CONTROL_REG_OFS, 32'h00000000);
        run(mk(OP_OTHER, 11'h200), 1'b1);
        rd(FP_STATUS_CONTROL_REG_OFS, 32'h00020000);
        rd(SRC_OFS, 32'h00000020);
    endtask
    task automatic t_enables();
        logic [31:0] en [4] = '{32'h00000080, 32'h00000200, 32'h00000800, 32'h00000400};
        op_e k [4] = '{OP_INNER, OP_OTHER, OP_MATRIX, OP_DIV};
        logic [10:0] b [4] = '{11'h000, 11'h008, 11'h000, 11'h080};
        logic [31:0] c [4] = '{32'h00001004, 32'h00000000, 32'h00001004, 32'h00008020};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, FP_STATUS_CONTROL_REG_OFS, en[i]);
            run(mk(k[i], b[i]), 1'b1);
            rd(FP_STATUS_CONTROL_REG_OFS, en[i] | c[i]);
        end
        rd(EVT_OFS, 32'h00000005);
    endtask
    task automatic t_graphics();
        apb(1'b1, FP_STATUS_CONTROL_REG_OFS, 32'h00000000);
        run(mk(OP_BANK, 11'h000), 1'b0);
        chk(op_ready_o, 1'b1);
        rd(FP_STATUS_CONTROL_REG_OFS, 32'h00200000);
        for (int i = 0; i < 2; i++) begin
            run(mk(OP_SIZE, 11'h000), 1'b0);
            run(mk(OP_MOVE, 11'h000), 1'b0);
            chk(r.pair_xfer, 1'(i == 0));
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_disable();
        t_untrapped();
        t_denorm();
        t_enables();
        t_graphics();
        final_report();
    end
    // The whole run needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
endmodule
`default_nettype wire
